// ### hdl/oag_pkg.sv
package oag_pkg;

  // ----------------------------------------------------------------
  // Field layout and address modes
  // ----------------------------------------------------------------
  localparam logic [1:0]  MODE_REG     = 2'h0;
  localparam logic [1:0]  MODE_IND     = 2'h1;
  localparam logic [1:0]  MODE_SYM     = 2'h2;
  localparam logic [1:0]  MODE_AINC    = 2'h3;
  localparam logic [3:0]  NO_INDEX     = 4'h0;

  // ----------------------------------------------------------------
  // Increments, opcodes and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WORD_INC     = 16'h0002;
  localparam logic [15:0] BYTE_INC     = 16'h0001;
  localparam logic [15:0] PC_STEP      = 16'h0002;
  localparam logic [15:0] ZERO_WORD    = 16'h0000;
  localparam logic [2:0]  OP_MOVE      = 3'h6;
  localparam logic [3:0]  JUMP_GROUP   = 4'h1;
  localparam logic [3:0]  JUMP_LAST    = 4'hC;
  localparam logic [7:0]  IMM_GROUP    = 8'h02;
  localparam logic [10:0] IMM_MASK_OP  = 11'h018;
  localparam logic [2:0]  SUB_STORE_WP = 3'h5;
  localparam logic [2:0]  SUB_STORE_SW = 3'h6;
  localparam logic [2:0]  SUB_LOAD_WP  = 3'h7;
  localparam logic [1:0]  BE_WORD      = 2'h3;
  localparam logic [1:0]  BE_LEFT      = 2'h2;
  localparam logic [1:0]  BE_RIGHT     = 2'h1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] opcode;
    logic       byte_op;
    logic [1:0] dst_mode;
    logic [3:0] dest_reg_field;
    logic [1:0] src_mode;
    logic [3:0] src_reg_field;
  } oag_dual_t;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [1:0]  be;
    logic [15:0] addr;
    logic [15:0] wdata;
  } oag_mem_t;

  typedef enum logic [2:0] {
    KIND_DUAL, KIND_JUMP, KIND_IMM, KIND_OTHER
  } oag_kind_t;

  typedef enum logic [1:0] {
    IMM_TO_REG, IMM_TO_WP, IMM_TO_MASK, IMM_NONE
  } oag_imm_t;

  typedef struct packed {
    oag_kind_t   kind;
    logic        byte_op;
    logic [15:0] src_ea;
    logic [15:0] dst_ea;
    logic [15:0] imm;
    oag_imm_t    imm_target;
    logic [3:0]  imm_reg;
    logic        jump_taken;
    logic        moved;
  } oag_result_t;

  typedef enum {
    S_IDLE, S_FETCH, S_OPND, S_REG_RD, S_INC_WR, S_EXT_RD, S_IDX_RD,
    S_MOV_RD, S_MOV_WR, S_IMM_RD, S_DONE
  } oag_state_t;

endpackage : oag_pkg

// ### hdl/oag_ea_unit.sv
`timescale 1ns/1ps
module oag_ea_unit
  import oag_pkg::*;
(
  input  wire logic [15:0] wp_in,
  input  wire logic [3:0]  reg_num_in,
  input  wire logic        byte_op_in,
  input  wire logic [15:0] base_in,
  input  wire logic [15:0] addend_in,
  output logic      [15:0] reg_addr_out,
  output logic      [15:0] inc_out,
  output logic      [15:0] sum_out
);

  // ----------------------------------------------------------------
  // Workspace register address, increment and index sum
  // ----------------------------------------------------------------
  assign reg_addr_out = wp_in + {11'h000, reg_num_in, 1'b0};
  assign inc_out      = base_in + (byte_op_in ? BYTE_INC : WORD_INC);
  assign sum_out      = base_in + addend_in;

endmodule : oag_ea_unit

// ### hdl/oag_core.sv
// Operation
// - Autoincrement mode: register is operand address, then add one (byte) or two.
// - Word addresses are always even; byte operations may use odd addresses.
// - Mode 10 with register zero: next stream word is the effective address.
// - Source extension word comes first, destination extension word second.
// - Mode 10 with nonzero register: extension word plus register contents.
// - Only symbolic mode indexes; indirect addresses come only from registers.
// - Immediate value goes with a register, or into workspace pointer or mask.
// - Relative jumps change the counter always or when status condition holds.
// - Dual-operand word: opcode, byte flag, dest mode/reg, source mode/reg.
// - Move copies the value read at source to the destination address.
// - Byte flag one selects byte operands and addresses, zero selects words.
// - Indirect mode reads the register and uses its value as operand address.
// - Byte access to a workspace register uses its left, most significant byte.
// - Each four-bit register field selects one of sixteen workspace registers.
`timescale 1ns/1ps
module oag_core
  import oag_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [15:0] wp_in,
  input  wire logic [15:0] status_word_in,
  input  wire logic        mem_ack_in,
  input  wire logic [15:0] mem_rdata_in,
  output oag_mem_t         mem_out,
  output logic             busy_out,
  output logic             done_out,
  output oag_result_t      result_out,
  output logic      [15:0] pc_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic oag_mem_t mem_rd(input logic [15:0] addr);
    oag_mem_t m;
    m       = '0;
    m.req   = 1'b1;
    m.be    = BE_WORD;
    m.addr  = {addr[15:1], 1'b0};
    return m;
  endfunction : mem_rd

  function automatic oag_mem_t mem_wr(input logic [15:0] addr,
                                      input logic [15:0] data,
                                      input logic [1:0]  be);
    oag_mem_t m;
    m       = '0;
    m.req   = 1'b1;
    m.we    = 1'b1;
    m.be    = be;
    m.addr  = addr;
    m.wdata = data;
    return m;
  endfunction : mem_wr

  function automatic logic [15:0] fix_ea(input logic [15:0] ea,
                                         input logic        byte_op);
    fix_ea = byte_op ? ea : {ea[15:1], 1'b0};
  endfunction : fix_ea

  function automatic logic jump_cond(input logic [3:0]  op,
                                     input logic [15:0] sw);
    logic lgt;
    logic agt;
    logic eq;
    logic cy;
    logic ov;
    logic par;
    lgt = sw[15];
    agt = sw[14];
    eq  = sw[13];
    cy  = sw[12];
    ov  = sw[11];
    par = sw[10];
    case (op)
      4'h0:    jump_cond = 1'b1;
      4'h1:    jump_cond = !agt && !eq;
      4'h2:    jump_cond = !lgt || eq;
      4'h3:    jump_cond = eq;
      4'h4:    jump_cond = lgt || eq;
      4'h5:    jump_cond = agt;
      4'h6:    jump_cond = !eq;
      4'h7:    jump_cond = !cy;
      4'h8:    jump_cond = cy;
      4'h9:    jump_cond = !ov;
      4'hA:    jump_cond = !lgt && !eq;
      4'hB:    jump_cond = lgt && !eq;
      4'hC:    jump_cond = par;
      default: jump_cond = 1'b0;
    endcase
  endfunction : jump_cond

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  oag_state_t  state_r;
  oag_dual_t   instr_r;
  oag_mem_t    mem_r;
  oag_result_t res_r;
  logic [15:0] pc_r;
  logic [15:0] wp_r;
  logic [15:0] stat_r;
  logic [15:0] ext_r;
  logic [15:0] ea_r [2];
  logic        cur_dst_r;
  logic        done_r;
  logic [1:0]  cur_mode;
  logic [3:0]  cur_reg;
  logic [15:0] reg_addr;
  logic [15:0] inc_val;
  logic [15:0] idx_sum;
  logic [15:0] rword;
  logic        is_move;

  // ----------------------------------------------------------------
  // Field selection for the operand in progress
  // ----------------------------------------------------------------
  assign cur_mode = cur_dst_r ? instr_r.dst_mode : instr_r.src_mode;
  assign cur_reg  = cur_dst_r ? instr_r.dest_reg_field
                              : instr_r.src_reg_field;
  assign is_move  = (instr_r.opcode == OP_MOVE);
  assign rword    = {mem_rdata_in[15:8], mem_rdata_in[7:0]};

  oag_ea_unit u_ea (
    .wp_in        (wp_r),
    .reg_num_in   (cur_reg),
    .byte_op_in   (instr_r.byte_op),
    .base_in      (rword),
    .addend_in    (ext_r),
    .reg_addr_out (reg_addr),
    .inc_out      (inc_val),
    .sum_out      (idx_sum)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r    <= S_IDLE;
      instr_r    <= '0;
      mem_r      <= '0;
      res_r      <= '0;
      pc_r       <= ZERO_WORD;
      wp_r       <= ZERO_WORD;
      stat_r     <= ZERO_WORD;
      ext_r      <= ZERO_WORD;
      ea_r[0]    <= ZERO_WORD;
      ea_r[1]    <= ZERO_WORD;
      cur_dst_r  <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (mem_r.req && mem_ack_in) begin
        mem_r.req <= 1'b0;
      end
      case (state_r)
        S_IDLE: begin
          if (start_in) begin
            pc_r    <= pc_in;
            wp_r    <= wp_in;
            stat_r  <= status_word_in;
            res_r   <= '0;
            mem_r   <= mem_rd(pc_in);
            state_r <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack_in) begin
            instr_r   <= rword;
            cur_dst_r <= 1'b0;
            pc_r      <= pc_r + PC_STEP;
            if (rword[15:14] != 2'h0) begin
              res_r.kind    <= KIND_DUAL;
              res_r.byte_op <= rword[12];
              state_r       <= S_OPND;
            end else if (rword[15:12] == JUMP_GROUP &&
                         rword[11:8] <= JUMP_LAST) begin
              res_r.kind <= KIND_JUMP;
              if (jump_cond(rword[11:8], stat_r)) begin
                res_r.jump_taken <= 1'b1;
                pc_r <= pc_r + PC_STEP +
                        {{7{rword[7]}}, rword[7:0], 1'b0};
              end
              state_r <= S_DONE;
            end else if ((rword[15:8] == IMM_GROUP &&
                          rword[7:5] != SUB_STORE_WP &&
                          rword[7:5] != SUB_STORE_SW) ||
                         rword[15:5] == IMM_MASK_OP) begin
              res_r.kind    <= KIND_IMM;
              res_r.imm_reg <= rword[3:0];
              if (rword[15:5] == IMM_MASK_OP) begin
                res_r.imm_target <= IMM_TO_MASK;
              end else if (rword[7:5] == SUB_LOAD_WP) begin
                res_r.imm_target <= IMM_TO_WP;
              end else begin
                res_r.imm_target <= IMM_TO_REG;
              end
              mem_r   <= mem_rd(pc_r + PC_STEP);
              pc_r    <= pc_r + PC_STEP + PC_STEP;
              state_r <= S_IMM_RD;
            end else begin
              res_r.kind       <= KIND_OTHER;
              res_r.imm_target <= IMM_NONE;
              state_r          <= S_DONE;
            end
          end
        end
        S_OPND: begin
          case (cur_mode)
            MODE_REG: begin
              ea_r[cur_dst_r] <= reg_addr;
              if (!cur_dst_r) begin
                cur_dst_r <= 1'b1;
              end else if (is_move) begin
                mem_r   <= mem_rd(fix_ea(ea_r[0], instr_r.byte_op));
                state_r <= S_MOV_RD;
              end else begin
                state_r <= S_DONE;
              end
            end
            MODE_SYM: begin
              mem_r   <= mem_rd(pc_r);
              pc_r    <= pc_r + PC_STEP;
              state_r <= S_EXT_RD;
            end
            default: begin
              mem_r   <= mem_rd(reg_addr);
              state_r <= S_REG_RD;
            end
          endcase
        end
        S_REG_RD: begin
          if (mem_ack_in) begin
            ea_r[cur_dst_r] <= fix_ea(rword, instr_r.byte_op);
            if (cur_mode == MODE_AINC) begin
              mem_r   <= mem_wr(reg_addr, inc_val, BE_WORD);
              state_r <= S_INC_WR;
            end else begin
              state_r <= S_OPND;
              if (cur_dst_r) begin
                state_r <= is_move ? S_MOV_RD : S_DONE;
                mem_r   <= is_move ?
                           mem_rd(fix_ea(ea_r[0], instr_r.byte_op)) : '0;
              end
              cur_dst_r <= 1'b1;
            end
          end
        end
        S_INC_WR: begin
          if (mem_ack_in) begin
            state_r <= S_OPND;
            if (cur_dst_r) begin
              state_r <= is_move ? S_MOV_RD : S_DONE;
              mem_r   <= is_move ?
                         mem_rd(fix_ea(ea_r[0], instr_r.byte_op)) : '0;
            end
            cur_dst_r <= 1'b1;
          end
        end
        S_EXT_RD: begin
          if (mem_ack_in) begin
            if (cur_reg == NO_INDEX) begin
              ea_r[cur_dst_r] <= fix_ea(rword, instr_r.byte_op);
              state_r <= S_OPND;
              if (cur_dst_r) begin
                state_r <= is_move ? S_MOV_RD : S_DONE;
                mem_r   <= is_move ?
                           mem_rd(fix_ea(ea_r[0], instr_r.byte_op)) : '0;
              end
              cur_dst_r <= 1'b1;
            end else begin
              ext_r   <= rword;
              mem_r   <= mem_rd(reg_addr);
              state_r <= S_IDX_RD;
            end
          end
        end
        S_IDX_RD: begin
          if (mem_ack_in) begin
            ea_r[cur_dst_r] <= fix_ea(idx_sum, instr_r.byte_op);
            state_r <= S_OPND;
            if (cur_dst_r) begin
              state_r <= is_move ? S_MOV_RD : S_DONE;
              mem_r   <= is_move ?
                         mem_rd(fix_ea(ea_r[0], instr_r.byte_op)) : '0;
            end
            cur_dst_r <= 1'b1;
          end
        end
        S_MOV_RD: begin
          if (mem_ack_in) begin
            if (instr_r.byte_op) begin
              mem_r <= mem_wr(ea_r[1], ea_r[0][0] ? {2{rword[7:0]}}
                                                  : {2{rword[15:8]}},
                              ea_r[1][0] ? BE_RIGHT : BE_LEFT);
            end else begin
              mem_r      <= mem_wr(ea_r[1], rword, BE_WORD);
            end
            state_r <= S_MOV_WR;
          end
        end
        S_MOV_WR: begin
          if (mem_ack_in) begin
            res_r.moved <= 1'b1;
            state_r     <= S_DONE;
          end
        end
        S_IMM_RD: begin
          if (mem_ack_in) begin
            res_r.imm <= rword;
            state_r   <= S_DONE;
          end
        end
        S_DONE: begin
          res_r.src_ea <= ea_r[0];
          res_r.dst_ea <= ea_r[1];
          done_r       <= 1'b1;
          state_r      <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mem_out    = mem_r;
  assign busy_out   = (state_r != S_IDLE);
  assign done_out   = done_r;
  assign result_out = res_r;
  assign pc_out     = pc_r;

endmodule : oag_core

// ### test/oag_mem_model.sv
`timescale 1ns/1ps
module oag_mem_model
  import oag_pkg::*;
(
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        slow_in,
  input  wire oag_mem_t    mem_in,
  output logic             ack_out,
  output logic      [15:0] rdata_out
);
  // ----
  // Word memory, answers after zero or one wait cycle
  // ----
  logic [15:0] mem [0:32767];
  logic        wait_r;

  always @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      wait_r <= 1'b0;
      rdata_out <= 16'hA5A5;
    end else if (mem_in.req && !ack_out && (!slow_in || wait_r)) begin
      ack_out <= 1'b1;
      wait_r <= 1'b0;
      if (mem_in.we) begin
        rdata_out <= ~rdata_out;
        if (mem_in.be[1])
          mem[mem_in.addr[15:1]][15:8] <= mem_in.wdata[15:8];
        if (mem_in.be[0])
          mem[mem_in.addr[15:1]][7:0] <= mem_in.wdata[7:0];
      end else begin
        rdata_out <= mem[mem_in.addr[15:1]];
      end
    end else begin
      ack_out <= 1'b0;
      wait_r <= mem_in.req;
      rdata_out <= ~rdata_out;
    end
  end
endmodule : oag_mem_model

// ### test/oag_core_asserts.sv
`timescale 1ns/1ps
module oag_core_asserts
  import oag_pkg::*;
(
  input wire logic        sys_clk_in,
  input wire logic        rst_n_in,
  input wire logic        start_in,
  input wire logic [15:0] pc_in,
  input wire logic [15:0] wp_in,
  input wire logic [15:0] status_word_in,
  input wire logic        mem_ack_in,
  input wire logic [15:0] mem_rdata_in,
  input wire oag_mem_t    mem_out,
  input wire logic        busy_out,
  input wire logic        done_out,
  input wire oag_result_t result_out,
  input wire logic [15:0] pc_out
);
  // ----
  // Captured instruction and counter
  // ----
  logic        fetch_r;
  logic [15:0] pc_cap_r;
  logic [15:0] instr_r;
  logic [15:0] jtgt;

  assign jtgt = pc_cap_r + 16'h0002 + {{7{instr_r[7]}}, instr_r[7:0], 1'b0};

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fetch_r <= 1'b0;
      pc_cap_r <= 16'h0000;
    end else if (start_in && !busy_out) begin
      fetch_r <= 1'b1;
      pc_cap_r <= pc_in;
    end else if (mem_ack_in) begin
      fetch_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      instr_r <= 16'h0000;
    else if (fetch_r && mem_ack_in)
      instr_r <= mem_rdata_in;
  end

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  AST_FETCH_FIRST: assert property (start_in && !busy_out |=> mem_out.req &&
    !mem_out.we && mem_out.addr == $past(pc_in))
    else $error("first access is not the fetch at pc");
  AST_REQ_HOLD: assert property (mem_out.req && !mem_ack_in |=> mem_out.req &&
    $stable(mem_out.addr) && $stable(mem_out.we))
    else $error("request changed before ack");
  AST_IDLE_QUIET: assert property (!busy_out |-> !mem_out.req)
    else $error("memory request while idle");
  AST_DONE_PULSE: assert property (done_out |=> !done_out)
    else $error("done longer than one cycle");
  AST_DONE_BOUND: assert property (start_in && !busy_out |-> ##[3:80] done_out)
    else $error("instruction not finished in time");
  AST_WORD_EVEN: assert property (done_out && result_out.kind == KIND_DUAL &&
    !result_out.byte_op |-> !result_out.src_ea[0] && !result_out.dst_ea[0])
    else $error("word address odd");
  AST_BE_LANE: assert property (mem_out.req && mem_out.be != BE_WORD |->
    mem_out.addr[0] == (mem_out.be == BE_RIGHT))
    else $error("byte lane does not match address");
  AST_WORD_BE: assert property (mem_out.req && mem_out.be == BE_WORD |->
    !mem_out.addr[0])
    else $error("word access at odd address");
  AST_JUMP_PC: assert property (done_out && result_out.kind == KIND_JUMP |->
    pc_out == (result_out.jump_taken ? jtgt : pc_cap_r + 16'h0002))
    else $error("jump target wrong");

  CV_JUMP: cover property (done_out && result_out.jump_taken);
  CV_IMM: cover property (done_out && result_out.kind == KIND_IMM);
  CV_MOVE: cover property (done_out && result_out.moved);
endmodule : oag_core_asserts

bind oag_core oag_core_asserts u_chk (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .start_in(start_in), .pc_in(pc_in), .wp_in(wp_in),
  .status_word_in(status_word_in), .mem_ack_in(mem_ack_in),
  .mem_rdata_in(mem_rdata_in), .mem_out(mem_out), .busy_out(busy_out),
  .done_out(done_out), .result_out(result_out), .pc_out(pc_out));

// ### test/oag_core_bench.sv
`timescale 1ns/1ps
module oag_core_bench;
  import oag_pkg::*;
  typedef struct {
    logic [15:0] kind, a, b, pc, m1, v1, m2, v2;
  } oag_exp_t;
  localparam logic [15:0] WP = 16'h0400;
  localparam logic [15:0] IOP [4] = '{16'h0202, 16'h0225, 16'h02E0, 16'h0300};
  localparam logic [15:0] ITG [4] = '{16'h0008, 16'h0014, 16'h0001, 16'h0002};
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        start_in = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] pc_in = 16'h0000;
  logic [15:0] wp_in = 16'h0000;
  logic [15:0] status_word_in = 16'h0000;
  logic [15:0] lfsr_r = 16'h0043;
  logic        mem_ack_in;
  logic [15:0] mem_rdata_in;
  oag_mem_t    mem_out;
  logic        busy_out;
  logic        done_out;
  oag_result_t result_out;
  logic [15:0] pc_out;
  int          miscompares = 0;
  int          check_count = 0;
  oag_exp_t    q[$];
  oag_exp_t    e;

  oag_core dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .start_in(start_in), .pc_in(pc_in), .wp_in(wp_in),
    .status_word_in(status_word_in), .mem_ack_in(mem_ack_in),
    .mem_rdata_in(mem_rdata_in), .mem_out(mem_out), .busy_out(busy_out),
    .done_out(done_out), .result_out(result_out), .pc_out(pc_out));
  oag_mem_model mm (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .slow_in(slow), .mem_in(mem_out), .ack_out(mem_ack_in),
    .rdata_out(mem_rdata_in));

  initial forever #20 sys_clk_in = ~sys_clk_in;

  // ----
  // Helpers
  // ----
  function automatic logic [15:0] rnd();
    lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    return lfsr_r;
  endfunction : rnd

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task summarize;
    if (miscompares == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task setw(input logic [15:0] a, input logic [15:0] v);
    mm.mem[a[15:1]] = v;
  endtask : setw

  function automatic logic cond(input logic [3:0] c, input logic [15:0] s);
    case (c)
      4'h0: return 1'b1;
      4'h1: return !s[14] && !s[13];
      4'h2: return !s[15] || s[13];
      4'h3: return s[13];
      4'h4: return s[15] || s[13];
      4'h5: return s[14];
      4'h6: return !s[13];
      4'h7: return !s[12];
      4'h8: return s[12];
      4'h9: return !s[11];
      4'hA: return !s[15] && !s[13];
      4'hB: return s[15] && !s[13];
      default: return s[10];
    endcase
  endfunction : cond

  task automatic run(input logic [15:0] pc, sw, w0, w1, w2, input oag_exp_t x);
    int n;
    logic [15:0] t;
    setw(pc, w0);
    setw(pc + 16'h0002, w1);
    setw(pc + 16'h0004, w2);
    q.push_back(x);
    t = rnd();
    @(posedge sys_clk_in);
    #1;
    slow = t[0];
    pc_in = pc;
    wp_in = WP;
    status_word_in = sw;
    start_in = 1'b1;
    @(posedge sys_clk_in);
    #1;
    start_in = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 200) begin
      @(posedge sys_clk_in);
      #3;
      n++;
    end
    if (n == 200) begin
      miscompares++;
      $display("mismatch at %0t: no done", $time);
      summarize();
    end
  endtask : run

  // ----
  // Result monitor
  // ----
  always @(posedge sys_clk_in) begin
    #2;
    if (done_out === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk({13'h0, result_out.kind}, e.kind);
      chk(pc_out, e.pc);
      if (e.kind == 16'h0) begin
        chk(result_out.src_ea, e.a);
        chk(result_out.dst_ea, e.b);
      end else if (e.kind == 16'h1) begin
        chk({15'h0, result_out.jump_taken}, e.a);
      end else begin
        chk(result_out.imm, e.a);
        chk({10'h0, (result_out.imm_target == IMM_TO_REG) ?
          result_out.imm_reg : 4'h0, result_out.imm_target}, e.b);
      end
      if (e.m1 != 16'h0)
        chk(mm.mem[e.m1[15:1]], e.v1);
      if (e.m2 != 16'h0)
        chk(mm.mem[e.m2[15:1]], e.v2);
    end
  end

  // ----
  // Scenarios
  // ----
  initial begin
    logic [15:0] v;
    logic [15:0] t;
    logic [15:0] x;
    logic [3:0]  c;
    repeat (16) @(posedge sys_clk_in);
    #1;
    rst_n_in = 1'b1;
    v = rnd();
    setw(16'hFF00, v);
    setw(16'hFF06, ~v);
    setw(WP + 16'h0002, 16'h0004);
    run(16'h1000, 16'h0, 16'hC860, 16'hFF00, 16'hFF02, '{16'h0, 16'hFF00,
      16'hFF06, 16'h1006, 16'hFF06, v, 16'h0, 16'h0});
    setw(16'hFF0A, ~v);
    setw(16'hFF08, v);
    run(16'h1100, 16'h0, 16'hC820, 16'hFF0A, 16'hFF08, '{16'h0, 16'hFF0A,
      16'hFF08, 16'h1106, 16'hFF08, ~v, 16'h0, 16'h0});
    setw(WP + 16'h0002, v);
    setw(WP + 16'h0008, 16'hFD00);
    setw(16'hFD00, ~v);
    run(16'h1200, 16'h0, 16'hC501, 16'h0, 16'h0, '{16'h0, WP + 16'h0002,
      16'hFD00, 16'h1202, 16'hFD00, v, 16'h0, 16'h0});
    setw(WP + 16'h0008, 16'h3000);
    setw(16'h3000, v);
    setw(WP + 16'h000A, ~v);
    run(16'h1300, 16'h0, 16'hC174, 16'h0, 16'h0, '{16'h0, 16'h3000,
      WP + 16'h000A, 16'h1302, WP + 16'h000A, v, WP + 16'h0008, 16'h3002});
    setw(WP + 16'h0008, 16'h2101);
    setw(16'h2100, v);
    setw(WP + 16'h000A, 16'h0000);
    run(16'h1400, 16'h0, 16'hD174, 16'h0, 16'h0, '{16'h0, 16'h2101,
      WP + 16'h000A, 16'h1402, WP + 16'h000A, {v[7:0], 8'h00},
      WP + 16'h0008, 16'h2102});
    run(16'h1600, 16'h0, 16'h02A0, 16'h0, 16'h0, '{16'h3, 16'h0,
      16'h3, 16'h1602, 16'h0, 16'h0, 16'h0, 16'h0});
    run(16'h1700, 16'h0, 16'h2800, 16'h0, 16'h0, '{16'h3, 16'h0,
      16'h3, 16'h1702, 16'h0, 16'h0, 16'h0, 16'h0});
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      run(16'h1500, 16'h0, IOP[i], v, 16'h0, '{16'h2, v, ITG[i],
        16'h1504, 16'h0, 16'h0, 16'h0, 16'h0});
    end
    for (int i = 0; i < 39; i++) begin
      c = 4'(i % 13);
      v = rnd();
      t = rnd();
      x = cond(c, t) ? 16'h2002 + {{7{v[7]}}, v[7:0], 1'b0} : 16'h2002;
      run(16'h2000, t, {4'h1, c, v[7:0]}, 16'h0, 16'h0, '{16'h1,
        {15'h0, cond(c, t)}, 16'h0, x, 16'h0, 16'h0, 16'h0, 16'h0});
    end
    repeat (4) @(posedge sys_clk_in);
    summarize();
  end
endmodule : oag_core_bench
